//--- core/ckpd_clock_ctrl.sv
`timescale 1ns/1ns
// How it works
// - Power-down is entered on WFI only when enable and wait bits are both 1.
// - Power-down lasts until a wake-up interrupt arrives, then the device runs again.
// - Crystal and fast RC oscillator enables drop while in Power-down.
// - Slow RC keeps running; watchdog/timer clocks only if on slow RC; rest gated.
// - PLL reference is fast RC when only the fast RC enable bit is set, else crystal.
// - System clock source comes from clock select register 0 bits 2..0.
// - SysTick uses core clock or external source from select bits 5..3.
// - Divider is sixteen halving stages with a sixteen-way tap select.
// - Output frequency is system clock over two to the power N plus one.
// - Writing divider enable 1 starts the chain counting.
// - Writing enable 0 runs the chain until output is low, then holds low.
// - Bypass bit with divider enable 1 sends the synchronised divider input to the output pin.
// - Each peripheral has its own clock gate, source select and divider.
module ckpd_clock_ctrl
	import ckpd_pkg::*;
#(
	parameter int NUM_PER = 8,
	parameter int WDT_IDX = 0,
	parameter int TMR_IDX = 1
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Core handshake
	input wire logic i_wfi,
	input wire logic i_wakeup_irq,
	input wire logic i_systick_csr_clksrc,
	// Divider input, sampled level from the clock tree
	input wire logic i_divider_input_clock,
	// Clock source and gate controls
	output logic o_external_fast_crystal_en,
	output logic o_internal_fast_rc_en,
	output logic o_internal_slow_rc_en,
	output logic o_pll_ref_is_rc,
	output logic [2:0] o_sys_src_sel,
	output logic o_core_clk_en,
	output logic o_sys_clk_en,
	output logic o_systick_use_ext,
	output logic [2:0] o_systick_ext_source_select,
	output logic [NUM_PER-1:0] o_per_clk_en,
	output logic [2*NUM_PER-1:0] o_per_src_sel,
	output logic [4*NUM_PER-1:0] o_per_div,
	output logic o_power_down,
	// Divided clock output pin
	output logic o_divided_clock_output_pin
);
	////////////////////////////////////////////////////////////////////////////
	initial begin
		if (NUM_PER < 2 || NUM_PER > 16) $error("NUM_PER must be 2..16");
		if (WDT_IDX >= NUM_PER || TMR_IDX >= NUM_PER) $error("bad peripheral index");
	end

	function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
		is_reg = (a == off);
	endfunction : is_reg

	// Status is assembled in one place so the read mux keeps one bit order
	function automatic logic [31:0] status_word(input logic pin, input logic div_en, input ckpd_mode_type m);
		status_word = {28'h0000000, pin, div_en, (m == PM_SLEEP), (m == PM_PDOWN)};
	endfunction : status_word

	// A peripheral slot counts as slow-clocked only on the slow RC source code
	function automatic logic on_slow_rc(input logic [1:0] code);
		on_slow_rc = (code == SRC_LRC[1:0]);
	endfunction : on_slow_rc

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [31:0] pwr_ff, nxt_pwr;
	logic [5:0] sel0_ff, nxt_sel0;
	logic [5:0] divc_ff, nxt_divc;
	logic [NUM_PER-1:0] pen_ff, nxt_pen;
	logic [2*NUM_PER-1:0] psel_ff, nxt_psel;
	logic [4*NUM_PER-1:0] pdiv_ff, nxt_pdiv;
	logic [31:0] rdata_ff, nxt_rdata;
	ckpd_mode_type mode_ff, nxt_mode;

	always_comb begin
		nxt_pwr = pwr_ff;
		nxt_sel0 = sel0_ff;
		nxt_divc = divc_ff;
		nxt_pen = pen_ff;
		nxt_psel = psel_ff;
		nxt_pdiv = pdiv_ff;
		nxt_rdata = 32'h0000_0000;
		// Bits above the wait bit are reserved and always read back as zero
		if (i_wr) begin
			if (is_reg(i_addr, ADDR_PWR_CTL)) nxt_pwr = {23'h000000, i_wdata[8:0]};
			if (is_reg(i_addr, ADDR_CLK_SEL0)) nxt_sel0 = i_wdata[5:0];
			if (is_reg(i_addr, ADDR_DIV_CTL)) nxt_divc = i_wdata[5:0];
			if (is_reg(i_addr, ADDR_PER_EN)) nxt_pen = i_wdata[NUM_PER-1:0];
			if (is_reg(i_addr, ADDR_PER_SEL)) nxt_psel = i_wdata[2*NUM_PER-1:0];
			if (is_reg(i_addr, ADDR_PER_DIV)) nxt_pdiv = i_wdata[4*NUM_PER-1:0];
		end
		if (i_rd) begin
			case (i_addr)
				ADDR_PWR_CTL: nxt_rdata = pwr_ff;
				ADDR_CLK_SEL0: nxt_rdata = {26'h0000000, sel0_ff};
				ADDR_DIV_CTL: nxt_rdata = {26'h0000000, divc_ff};
				ADDR_PER_EN: nxt_rdata = 32'(pen_ff);
				ADDR_PER_SEL: nxt_rdata = 32'(psel_ff);
				ADDR_PER_DIV: nxt_rdata = 32'(pdiv_ff);
				ADDR_STATUS: nxt_rdata = status_word(o_divided_clock_output_pin, divc_ff[DIV_EN_BIT], mode_ff);
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			pwr_ff <= PWR_CTL_RST;
			sel0_ff <= 6'h00;
			divc_ff <= 6'h00;
			pen_ff <= '0;
			psel_ff <= '0;
			pdiv_ff <= '0;
			rdata_ff <= ZERO_RST;
		end else begin
			pwr_ff <= nxt_pwr;
			sel0_ff <= nxt_sel0;
			divc_ff <= nxt_divc;
			pen_ff <= nxt_pen;
			psel_ff <= nxt_psel;
			pdiv_ff <= nxt_pdiv;
			rdata_ff <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power mode sequencer
	// Sleep keeps every oscillator running, so waking from it costs no oscillator start-up time;
	// Power-down trades that start-up time for the lower standby current
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			PM_RUN: begin
				if (i_wfi && pwr_ff[PWR_PD_EN_BIT] && pwr_ff[PWR_PD_WAIT_BIT]) begin
					nxt_mode = PM_PDOWN;
				end else if (i_wfi) begin
					nxt_mode = PM_SLEEP;
				end
			end
			PM_SLEEP: begin
				if (i_wakeup_irq) nxt_mode = PM_RUN;
			end
			PM_PDOWN: begin
				if (i_wakeup_irq) nxt_mode = PM_RUN;
			end
			default: nxt_mode = PM_RUN;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			mode_ff <= PM_RUN;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock gating outputs
	logic pd;
	logic [NUM_PER-1:0] nxt_pen_out;
	assign pd = (nxt_mode == PM_PDOWN);

	logic [NUM_PER-1:0] per_on_lrc;
	logic [NUM_PER-1:0] per_keeps_clk;

	// Only the watchdog and timer slots may keep a clock in Power-down; every other slot is cut
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PER; gi++) begin : g_per
			assign per_on_lrc[gi] = on_slow_rc(psel_ff[2*gi +: 2]);
			assign per_keeps_clk[gi] = pen_ff[gi] && per_on_lrc[gi] && (gi == WDT_IDX || gi == TMR_IDX);
		end
	endgenerate

	// Gate decisions follow the next mode so the outputs switch with the state itself
	always_comb begin
		nxt_pen_out = pen_ff;
		if (pd) begin
			nxt_pen_out = per_keeps_clk;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_external_fast_crystal_en <= 1'b1;
			o_internal_fast_rc_en <= 1'b1;
			o_internal_slow_rc_en <= 1'b1;
			o_pll_ref_is_rc <= 1'b0;
			o_sys_src_sel <= SRC_XTAL;
			o_core_clk_en <= 1'b1;
			o_sys_clk_en <= 1'b1;
			o_systick_use_ext <= 1'b0;
			o_systick_ext_source_select <= SRC_XTAL;
			o_per_clk_en <= '0;
			o_per_src_sel <= '0;
			o_per_div <= '0;
			o_power_down <= 1'b0;
		end else begin
			o_external_fast_crystal_en <= nxt_pwr[PWR_XTAL_EN_BIT] && !pd;
			o_internal_fast_rc_en <= nxt_pwr[PWR_HRC_EN_BIT] && !pd;
			o_internal_slow_rc_en <= 1'b1;
			o_pll_ref_is_rc <= nxt_pwr[PWR_HRC_EN_BIT] && !nxt_pwr[PWR_XTAL_EN_BIT];
			o_sys_src_sel <= nxt_sel0[SEL0_SYS_LSB +: 3];
			o_core_clk_en <= (nxt_mode == PM_RUN);
			o_sys_clk_en <= !pd;
			o_systick_use_ext <= !i_systick_csr_clksrc;
			o_systick_ext_source_select <= nxt_sel0[SEL0_ST_LSB +: 3];
			o_per_clk_en <= nxt_pen_out;
			o_per_src_sel <= nxt_psel;
			o_per_div <= nxt_pdiv;
			o_power_down <= pd;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frequency divider
	logic din_s1_ff, din_s2_ff;
	logic [DIV_STAGES-1:0] taps;
	logic nxt_divided_clock_output_pin;

	// The divider input arrives from another clock tree, so it is synchronised first.
	// Limitation: the bypassed pin can only follow inputs slower than half the system clock.
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			din_s1_ff <= 1'b0;
			din_s2_ff <= 1'b0;
		end else begin
			din_s1_ff <= i_divider_input_clock;
			din_s2_ff <= din_s1_ff;
		end
	end

	ckpd_div_chain #(
		.STAGES(DIV_STAGES)
	) u_chain (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_run(divc_ff[DIV_EN_BIT] && !pd),
		.i_sel(divc_ff[DIV_SEL_LSB +: 4]),
		.o_taps(taps)
	);

	always_comb begin
		if (divc_ff[DIV_BYP_BIT]) begin
			nxt_divided_clock_output_pin = din_s2_ff && divc_ff[DIV_EN_BIT];
		end else begin
			nxt_divided_clock_output_pin = taps[divc_ff[DIV_SEL_LSB +: 4]];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_divided_clock_output_pin <= 1'b0;
		end else begin
			o_divided_clock_output_pin <= nxt_divided_clock_output_pin;
		end
	end

	assign o_rdata = rdata_ff;
endmodule : ckpd_clock_ctrl

//--- shared/ckpd_pkg.sv
package ckpd_pkg;
	// Register offsets (byte addresses, one aligned word each)
	localparam logic [7:0] ADDR_PWR_CTL = 8'h00;
	localparam logic [7:0] ADDR_CLK_SEL0 = 8'h04;
	localparam logic [7:0] ADDR_DIV_CTL = 8'h08;
	localparam logic [7:0] ADDR_PER_EN = 8'h0C;
	localparam logic [7:0] ADDR_PER_SEL = 8'h10;
	localparam logic [7:0] ADDR_PER_DIV = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	// Field positions
	localparam int PWR_XTAL_EN_BIT = 0;
	localparam int PWR_HRC_EN_BIT = 2;
	localparam int PWR_PD_EN_BIT = 7;
	localparam int PWR_PD_WAIT_BIT = 8;
	localparam int SEL0_SYS_LSB = 0;
	localparam int SEL0_ST_LSB = 3;
	localparam int DIV_SEL_LSB = 0;
	localparam int DIV_EN_BIT = 4;
	localparam int DIV_BYP_BIT = 5;
	localparam int DIV_STAGES = 16;
	// Reset values
	localparam logic [31:0] PWR_CTL_RST = 32'h0000_0005;
	localparam logic [31:0] ZERO_RST = 32'h0000_0000;
	// Source codes: 0 crystal, 1 pll, 2 slow rc, 3 fast rc
	localparam logic [2:0] SRC_XTAL = 3'h0;
	localparam logic [2:0] SRC_PLL = 3'h1;
	localparam logic [2:0] SRC_LRC = 3'h2;
	localparam logic [2:0] SRC_HRC = 3'h3;
	typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_PDOWN} ckpd_mode_type;
endpackage : ckpd_pkg

//--- core/ckpd_div_chain.sv
`timescale 1ns/1ns
module ckpd_div_chain #(
	parameter int STAGES = 16
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// Control
	input wire logic i_run,
	input wire logic [3:0] i_sel,
	// Chain state
	output logic [STAGES-1:0] o_taps
);
	logic [STAGES-1:0] cnt_ff;
	logic [STAGES-1:0] nxt_cnt;

	initial begin
		if (STAGES != 16) $error("divider chain must have 16 stages");
	end

	// A binary counter is the chain of divide-by-two flops: bit k toggles at half bit k-1
	always_comb begin
		nxt_cnt = cnt_ff;
		if (i_run) begin
			nxt_cnt = cnt_ff + 16'h0001;
		end else if (cnt_ff[i_sel] == 1'b1) begin
			nxt_cnt = cnt_ff + 16'h0001;
		end else begin
			nxt_cnt = 16'h0000;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			cnt_ff <= 16'h0000;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign o_taps = cnt_ff;
endmodule : ckpd_div_chain

//--- verif/ckpd_clock_ctrl_chk.sv
`timescale 1ns/1ns
module ckpd_clock_ctrl_chk (
	// Clock, reset, core side
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_wfi,
	input wire logic i_wakeup_irq,
	input wire logic i_systick_csr_clksrc,
	// Watched outputs
	input wire logic o_external_fast_crystal_en,
	input wire logic o_internal_fast_rc_en,
	input wire logic o_internal_slow_rc_en,
	input wire logic o_core_clk_en,
	input wire logic o_sys_clk_en,
	input wire logic o_systick_use_ext,
	input wire logic o_power_down
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	pd_entry_a: assert property ($rose(o_power_down) |-> $past(i_wfi)) else $error("pd without wfi");
	halt_cause_a: assert property ($fell(o_core_clk_en) |-> $past(i_wfi)) else $error("halt without wfi");
	pd_osc_off_a: assert property (o_power_down |-> !o_external_fast_crystal_en && !o_internal_fast_rc_en)
		else $error("fast osc on in pd");
	pd_clk_off_a: assert property (o_power_down |-> !o_sys_clk_en && !o_core_clk_en) else $error("clk on in pd");
	slow_rc_on_a: assert property (o_internal_slow_rc_en) else $error("slow rc off");
	pd_wake_a: assert property (o_power_down && i_wakeup_irq |=> !o_power_down && o_sys_clk_en)
		else $error("no wake");
	pd_hold_a: assert property (o_power_down && !i_wakeup_irq |=> o_power_down) else $error("pd left early");
	sleep_sys_a: assert property (!o_core_clk_en && !o_power_down |-> o_sys_clk_en) else $error("sys off in sleep");
	st_src_a: assert property ($past(i_nrst) |-> o_systick_use_ext == !$past(i_systick_csr_clksrc))
		else $error("systick source");
	cover property ($rose(o_power_down));
	cover property ($fell(o_power_down));
	cover property (!o_core_clk_en && !o_power_down);
endmodule : ckpd_clock_ctrl_chk
bind ckpd_clock_ctrl ckpd_clock_ctrl_chk u_chk (.i_sys_clk, .i_nrst, .i_wfi, .i_wakeup_irq, .i_systick_csr_clksrc,
	.o_external_fast_crystal_en, .o_internal_fast_rc_en, .o_internal_slow_rc_en, .o_core_clk_en, .o_sys_clk_en,
	.o_systick_use_ext, .o_power_down);

//--- verif/ckpd_core_model.sv
`timescale 1ns/1ns
module ckpd_core_model (
	// Clock
	input wire logic i_sys_clk,
	// Toward the controller
	output logic o_wfi,
	output logic o_wakeup_irq
);
	initial begin
		o_wfi = 1'b0;
		o_wakeup_irq = 1'b0;
	end
	task automatic do_wfi();
		@(posedge i_sys_clk);
		o_wfi <= 1'b1;
		@(posedge i_sys_clk);
		o_wfi <= 1'b0;
	endtask : do_wfi
	task automatic do_wake();
		@(posedge i_sys_clk);
		o_wakeup_irq <= 1'b1;
		@(posedge i_sys_clk);
		o_wakeup_irq <= 1'b0;
	endtask : do_wake
endmodule : ckpd_core_model

//--- verif/test_chip_clock_and_power_down_control.sv
`timescale 1ns/1ns
module test_chip_clock_and_power_down_control;
	import ckpd_pkg::*;
	logic i_sys_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic i_systick_csr_clksrc = 1'b1, i_divider_input_clock = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0, o_rdata, o_per_div, v;
	wire logic i_wfi, i_wakeup_irq;
	logic o_external_fast_crystal_en, o_internal_fast_rc_en, o_internal_slow_rc_en, o_core_clk_en, o_sys_clk_en;
	logic o_systick_use_ext, o_power_down, o_divided_clock_output_pin, o_pll_ref_is_rc;
	logic [15:0] o_per_src_sel;
	logic [2:0] o_sys_src_sel, o_systick_ext_source_select;
	logic [7:0] o_per_clk_en;
	int num_errors = 0, n_checks = 0, seed = 23364, c;
	int regs[8];
	always #2 i_sys_clk = ~i_sys_clk;
	ckpd_clock_ctrl u_ckpd_clock_ctrl (.i_sys_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_wfi,
		.i_wakeup_irq, .i_systick_csr_clksrc, .i_divider_input_clock, .o_external_fast_crystal_en,
		.o_internal_fast_rc_en, .o_internal_slow_rc_en, .o_pll_ref_is_rc, .o_sys_src_sel, .o_core_clk_en,
		.o_sys_clk_en, .o_systick_use_ext, .o_systick_ext_source_select, .o_per_clk_en, .o_per_src_sel,
		.o_per_div, .o_power_down, .o_divided_clock_output_pin);
	ckpd_core_model u_core (.i_sys_clk, .o_wfi(i_wfi), .o_wakeup_irq(i_wakeup_irq));
	////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task nap(input int k);
		repeat (k) @(posedge i_sys_clk);
		#1;
	endtask : nap
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		regs[a[4:2]] = d;
	endtask : wr
	// Only mapped offsets and 0x1C are read; status is not modelled
	task rd(input logic [7:0] a);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, (a <= ADDR_PER_DIV) ? regs[a[4:2]] : 32'h0);
	endtask : rd
	task lvl(input logic l);
		#1;
		for (int i = 0; i < 300 && o_divided_clock_output_pin !== l; i++) nap(1);
	endtask : lvl
	task hi_len(input int n);
		wr(ADDR_DIV_CTL, 32'h10 | n);
		lvl(0);
		lvl(1);
		for (c = 0; c < 300 && o_divided_clock_output_pin === 1'b1; c++) nap(1);
		chk(c, 1 << n);
	endtask : hi_len
	task stop_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	////////////////
	initial begin
		#100000;
		num_errors++;
		stop_test();
	end
	initial begin
		regs = '{default: 0};
		repeat (6) @(posedge i_sys_clk);
		i_nrst <= 1'b1;
		regs[0] = PWR_CTL_RST;
		rd(ADDR_PWR_CTL);
		rd(8'h1C);
		v = $random(seed) & 32'h3F;
		wr(ADDR_CLK_SEL0, v);
		rd(ADDR_CLK_SEL0);
		chk({o_systick_ext_source_select, o_sys_src_sel}, v[5:0]);
		@(posedge i_sys_clk) i_systick_csr_clksrc <= 1'b0;
		nap(2);
		chk(o_systick_use_ext, 1'b1);
		v = $random(seed);
		wr(ADDR_PER_DIV, v);
		wr(ADDR_PER_SEL, {30'h0, SRC_LRC[1:0]});
		wr(ADDR_PER_EN, 32'hFF);
		rd(ADDR_PER_DIV);
		chk(o_per_clk_en, 8'hFF);
		chk(o_per_div, v);
		chk(o_per_src_sel, {14'h0, SRC_LRC[1:0]});
		chk(o_pll_ref_is_rc, 1'b0);
		wr(ADDR_PWR_CTL, 32'h04);
		nap(1);
		chk(o_pll_ref_is_rc, 1'b1);
		// One power-down bit only: core halts, oscillators stay
		wr(ADDR_PWR_CTL, 32'h85);
		u_core.do_wfi();
		nap(2);
		chk({o_power_down, o_core_clk_en, o_external_fast_crystal_en, o_sys_clk_en}, 4'b0011);
		u_core.do_wake();
		wr(ADDR_PWR_CTL, 32'h185);
		u_core.do_wfi();
		nap(12);
		chk({o_power_down, o_core_clk_en, o_external_fast_crystal_en, o_internal_fast_rc_en}, 4'b1000);
		chk({o_internal_slow_rc_en, o_per_clk_en}, 9'h101);
		u_core.do_wake();
		nap(2);
		chk({o_power_down, o_external_fast_crystal_en, o_sys_clk_en, o_per_clk_en}, 11'h3FF);
		for (int n = 0; n < 4; n++) hi_len(n);
		hi_len(7);
		lvl(1);
		wr(ADDR_DIV_CTL, 32'h07);
		for (c = 0; c < 300 && o_divided_clock_output_pin === 1'b1; c++) nap(1);
		chk(c, 126);
		for (c = 0; c < 300; c++) nap(1);
		chk(o_divided_clock_output_pin, 1'b0);
		wr(ADDR_DIV_CTL, 32'h30);
		repeat (6) begin
			v = $random(seed);
			@(posedge i_sys_clk) i_divider_input_clock <= v[0];
			nap(3);
			chk(o_divided_clock_output_pin, v[0]);
		end
		stop_test();
	end
endmodule : test_chip_clock_and_power_down_control
